// ==== logic/tpg_gpio.sv ====
`timescale 1ns/10ps
// Contract
// R1: Two bidirectional ports mapped in data memory.
// R2: Port B bits 7 and 6 read zero.
// R3: Input reads sample the live pin level.
// R4: Output latch holds until rewritten.
// R5: Pull-high bit: zero off, one on, reset zero.
// R6: Pull-high only for inputs or NMOS outputs.
// R7: Halt enters the low-power state.
// R8: Falling enabled port A pin wakes device.
// R9: Wake enable selectable per port A pin.
// R10: Wake only for GPIO pins while powered down.
// R11: Direction one is input, zero is output.
// R12: Output pins read back the latch.
// R13: Wake enable bit: zero off, one on, reset zero.
// R14: Reset makes all pins inputs, latches ones.
// R15: Wake request rises without a clock edge.
// R16: Whole-byte register access in one cycle.
module tpg_gpio (
  // Clock and reset.
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  // Core data-memory access.
  input  wire tpg_pkg::tpg_bus_s     core_req,
  output logic [7:0]                 core_rdata,
  output logic                       core_rvalid,
  // Port A pins.
  input  wire logic [7:0]            pa_in,
  input  wire logic [7:0]            pa_nmos_mode,
  input  wire logic [7:0]            pa_gpio_sel,
  output wire logic [7:0]            pa_out,
  output wire logic [7:0]            pa_oe,
  output wire logic [7:0]            pa_pull_en,
  // Port B pins.
  input  wire logic [5:0]            pb_in,
  input  wire logic [5:0]            pb_nmos_mode,
  output wire logic [5:0]            pb_out,
  output wire logic [5:0]            pb_oe,
  output wire logic [5:0]            pb_pull_en,
  // Power control.
  input  wire logic                  halt_exec,
  output wire logic                  power_down,
  output wire logic                  wake_req
);

  ////////////////////////////////////////////////////////////////////////////////
  // Port instances.
  logic       pa_rd_hit;
  logic [7:0] pa_rd_val;
  logic [7:0] pa_latch;
  logic [7:0] pa_dir;
  logic       pb_rd_hit;
  logic [7:0] pb_rd_val;
  logic [5:0] pb_latch;
  logic [5:0] pb_dir;

  // Both ports sit on the same data-memory strobe. [R1]
  tpg_port #(
    .W      (tpg_pkg::PA_W),
    .A_DATA (tpg_pkg::ADDR_PA_DATA),
    .A_DIR  (tpg_pkg::ADDR_PA_DIR),
    .A_PU   (tpg_pkg::ADDR_PA_PU)
  ) u_port_a (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .core_req  (core_req),
    .rd_hit    (pa_rd_hit),
    .rd_val    (pa_rd_val),
    .pin_in    (pa_in),
    .nmos_mode (pa_nmos_mode),
    .pin_out   (pa_out),
    .pin_oe    (pa_oe),
    .pull_en   (pa_pull_en),
    .latch     (pa_latch),
    .dir       (pa_dir)
  );

  tpg_port #(
    .W      (tpg_pkg::PB_W),
    .A_DATA (tpg_pkg::ADDR_PB_DATA),
    .A_DIR  (tpg_pkg::ADDR_PB_DIR),
    .A_PU   (tpg_pkg::ADDR_PB_PU)
  ) u_port_b (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .core_req  (core_req),
    .rd_hit    (pb_rd_hit),
    .rd_val    (pb_rd_val),
    .pin_in    (pb_in),
    .nmos_mode (pb_nmos_mode),
    .pin_out   (pb_out),
    .pin_oe    (pb_oe),
    .pull_en   (pb_pull_en),
    .latch     (pb_latch),
    .dir       (pb_dir)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Wake enable register.
  logic [7:0] wake_en;
  wire logic  hit_wake = tpg_pkg::tpg_hit(core_req.addr, tpg_pkg::ADDR_PA_WAKE);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wake_en <= tpg_pkg::RST_WAKE; // [R13]
    end else if (core_req.wr && hit_wake) begin
      wake_en <= core_req.wdata;    // [R9] [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path. The pin is sampled at the edge that takes the read, so the
  // core must present stable input by then; there is no input latch. [R3]
  wire logic [7:0] next_rdata = pa_rd_hit ? pa_rd_val :
                                (pb_rd_hit ? pb_rd_val :
                                (hit_wake ? wake_en : 8'h00));

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      core_rdata  <= 8'h00;
      core_rvalid <= 1'b0;
    end else begin
      core_rvalid <= core_req.rd;      // [R16]
      if (core_req.rd) begin
        core_rdata <= next_rdata;      // [R12] [R2]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power state and port A wake detection.
  tpg_pkg::tpg_pwr_e pwr_state;
  tpg_pkg::tpg_pwr_e next_pwr_state;
  logic [7:0]        pa_prev;

  // Last sampled pin levels. With the clock stopped this register simply
  // holds the level seen on entry, so the compare below still finds a fall.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pa_prev <= 8'h00;
    end else begin
      pa_prev <= pa_in;
    end
  end

  // Pure gates from pin to request: no clock edge is needed. [R15] [R8]
  wire logic [7:0] pa_fall   = pa_prev & ~pa_in;
  wire logic [7:0] wake_arm  = wake_en & pa_gpio_sel;             // [R9] [R10]
  wire logic       wake_hit  = (pwr_state == tpg_pkg::TPG_DOWN) && |(pa_fall & wake_arm); // [R10]

  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      tpg_pkg::TPG_RUN: begin
        if (halt_exec) begin
          next_pwr_state = tpg_pkg::TPG_DOWN; // [R7]
        end
      end
      tpg_pkg::TPG_DOWN: begin
        if (wake_hit) begin
          next_pwr_state = tpg_pkg::TPG_WAKE; // [R8]
        end
      end
      tpg_pkg::TPG_WAKE: begin
        next_pwr_state = tpg_pkg::TPG_RUN;
      end
      default: begin
        next_pwr_state = tpg_pkg::TPG_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pwr_state <= tpg_pkg::TPG_RUN;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  // The request is held through the waking cycle so a slow power
  // controller that sees the edge late still catches it.
  assign wake_req   = wake_hit || (pwr_state == tpg_pkg::TPG_WAKE); // [R8]
  assign power_down = (pwr_state == tpg_pkg::TPG_DOWN);            // [R7]

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_pb_upper_zero: assert property ( // [R2]
    core_req.rd && pb_rd_hit |=> core_rdata[7:6] == 2'b00)
    else $error("port B upper bits read non-zero");

  a_pa_readback: assert property ( // [R3]
    core_req.rd && tpg_pkg::tpg_hit(core_req.addr, tpg_pkg::ADDR_PA_DATA)
    |=> core_rdata == (($past(pa_dir) & $past(pa_in)) | (~$past(pa_dir) & $past(pa_latch))))
    else $error("port A read returned wrong mix of pin and latch");

  a_read_one_cycle: assert property ( // [R16]
    core_req.rd |=> core_rvalid)
    else $error("read answer not given one cycle later");

  a_halt_enters: assert property ( // [R7]
    pwr_state == tpg_pkg::TPG_RUN && halt_exec |=> power_down)
    else $error("halt did not enter power down");

  a_wake_sequence: assert property ( // [R8]
    wake_hit |-> wake_req ##1 (wake_req && !power_down) ##1
      (!wake_req && pwr_state == tpg_pkg::TPG_RUN))
    else $error("wake sequence wrong after enabled falling pin");

  a_wake_gated: assert property ( // [R10]
    (pwr_state != tpg_pkg::TPG_DOWN || (wake_en & pa_gpio_sel) == 8'h00)
    && pwr_state != tpg_pkg::TPG_WAKE |-> !wake_req)
    else $error("wake request without an armed pin in power down");

  a_wake_enable: assert property ( // [R9]
    power_down && |(pa_prev & ~pa_in & wake_en & pa_gpio_sel) |-> wake_req)
    else $error("armed falling pin did not raise wake request");

  a_reset_inputs: assert property (disable iff (1'b0) // [R14]
    $past(sys_rst) |-> pa_oe == 8'h00 && pb_oe == 6'h00
      && pa_latch == 8'hff && pb_latch == 6'h3f && pb_dir == 6'h3f && wake_en == 8'h00
      && !core_rvalid && core_rdata == 8'h00)
    else $error("pins not inputs after reset");

  a_pull_enable: assert property ( // [R5]
    core_req.wr && tpg_pkg::tpg_hit(core_req.addr, tpg_pkg::ADDR_PA_PU)
    |=> (pa_pull_en & pa_dir) == ($past(core_req.wdata) & pa_dir))
    else $error("pull-high on input pin does not follow its bit");

  a_pb_pull_write: assert property ( // [R5]
    core_req.wr && tpg_pkg::tpg_hit(core_req.addr, tpg_pkg::ADDR_PB_PU)
    |=> (pb_pull_en & pb_dir) == ($past(core_req.wdata[5:0]) & pb_dir))
    else $error("port B pull-high on input pin does not follow its bit");

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus answers. The read data stands so a core that looks late
  // still takes the last answer.
  a_rdata_stands: assert property ( // [R16]
    !core_req.rd |=> $stable(core_rdata))
    else $error("read data changed without a read");

  a_rvalid_pulse: assert property ( // [R16]
    !core_req.rd |=> !core_rvalid)
    else $error("read answer given without a read");

  a_unmapped_zero: assert property ( // [R1]
    core_req.rd && !pa_rd_hit && !pb_rd_hit && !hit_wake |=> core_rdata == 8'h00)
    else $error("unmapped read returned non-zero data");

  a_wake_write: assert property ( // [R9]
    core_req.wr && hit_wake |=> wake_en == $past(core_req.wdata))
    else $error("wake enable write did not land");

  a_wake_read: assert property ( // [R13]
    core_req.rd && hit_wake |=> core_rdata == $past(wake_en))
    else $error("wake enable read returned wrong value");

  a_pb_readback: assert property ( // [R12]
    core_req.rd && tpg_pkg::tpg_hit(core_req.addr, tpg_pkg::ADDR_PB_DATA)
    |=> core_rdata[5:0] == (($past(pb_dir) & $past(pb_in)) | (~$past(pb_dir) & $past(pb_latch))))
    else $error("port B read returned wrong mix of pin and latch");

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes and pin drive.
  a_pa_latch_write: assert property ( // [R4]
    core_req.wr && tpg_pkg::tpg_hit(core_req.addr, tpg_pkg::ADDR_PA_DATA)
    |=> pa_latch == $past(core_req.wdata))
    else $error("port A latch write did not land");

  a_pb_latch_write: assert property ( // [R2]
    core_req.wr && tpg_pkg::tpg_hit(core_req.addr, tpg_pkg::ADDR_PB_DATA)
    |=> pb_latch == $past(core_req.wdata[5:0]))
    else $error("port B latch write did not land");

  a_pa_dir_write: assert property ( // [R11]
    core_req.wr && tpg_pkg::tpg_hit(core_req.addr, tpg_pkg::ADDR_PA_DIR)
    |=> pa_dir == $past(core_req.wdata))
    else $error("port A direction write did not land");

  a_pb_dir_write: assert property ( // [R2]
    core_req.wr && tpg_pkg::tpg_hit(core_req.addr, tpg_pkg::ADDR_PB_DIR)
    |=> pb_dir == $past(core_req.wdata[5:0]))
    else $error("port B direction write did not land");

  a_input_released: assert property ( // [R11]
    (pa_oe & pa_dir) == 8'h00 && (pb_oe & pb_dir) == 6'h00)
    else $error("pin configured as input is driven");

  // A CMOS output must drive both levels; only an NMOS pin may let go.
  a_cmos_drives: assert property ( // [R11]
    (~pa_dir & ~pa_nmos_mode & ~pa_oe) == 8'h00
    && (~pb_dir & ~pb_nmos_mode & ~pb_oe) == 6'h00)
    else $error("CMOS output pin not driven");

  a_nmos_release: assert property ( // [R11]
    (pa_oe & pa_nmos_mode & pa_latch) == 8'h00
    && (pb_oe & pb_nmos_mode & pb_latch) == 6'h00)
    else $error("NMOS pin driven while its latch is one");

  ////////////////////////////////////////////////////////////////////////////////
  // Power state.
  a_down_holds: assert property ( // [R7]
    power_down && !wake_hit |=> power_down)
    else $error("power down left without a wake event");

  a_wake_leaves: assert property ( // [R8]
    pwr_state == tpg_pkg::TPG_WAKE |=> pwr_state == tpg_pkg::TPG_RUN)
    else $error("waking state did not return to run");

endmodule

// ==== inc/tpg_pkg.sv ====
package tpg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths of the data-memory port and of the two ports.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PA_W   = 8;
  localparam int unsigned PB_W   = 6;

  ////////////////////////////////////////////////////////////////////////////////
  // Data-memory addresses of the port registers.
  localparam logic [7:0] ADDR_PA_DATA = 8'h14;
  localparam logic [7:0] ADDR_PA_DIR  = 8'h15;
  localparam logic [7:0] ADDR_PA_PU   = 8'h16;
  localparam logic [7:0] ADDR_PA_WAKE = 8'h17;
  localparam logic [7:0] ADDR_PB_DATA = 8'h18;
  localparam logic [7:0] ADDR_PB_DIR  = 8'h19;
  localparam logic [7:0] ADDR_PB_PU   = 8'h1a;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] RST_DATA = 8'hff;
  localparam logic [7:0] RST_DIR  = 8'hff;
  localparam logic [7:0] RST_PU   = 8'h00;
  localparam logic [7:0] RST_WAKE = 8'h00;

  // Direction bit value that makes a pin an input.
  localparam logic DIR_INPUT = 1'b1;

  // Cycles from a taken read to its answer.
  localparam int unsigned READ_LAT = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // One core data-memory access.
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } tpg_bus_s;

  // Power state, Gray coded along run, down, waking.
  typedef enum logic [1:0] {
    TPG_RUN  = 2'b00,
    TPG_DOWN = 2'b01,
    TPG_WAKE = 2'b11
  } tpg_pwr_e;

  // Address decode shared by every register.
  function automatic logic tpg_hit(input logic [7:0] addr, input logic [7:0] target);
    tpg_hit = (addr == target);
  endfunction

endpackage

// ==== logic/tpg_port.sv ====
`timescale 1ns/10ps
module tpg_port #(
  parameter int unsigned     W      = 8,
  parameter logic [7:0]      A_DATA = 8'h00,
  parameter logic [7:0]      A_DIR  = 8'h01,
  parameter logic [7:0]      A_PU   = 8'h02
) (
  // Clock and reset.
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  // Core access.
  input  wire tpg_pkg::tpg_bus_s  core_req,
  output wire logic               rd_hit,
  output wire logic [7:0]         rd_val,
  // Pins.
  input  wire logic [W-1:0]       pin_in,
  input  wire logic [W-1:0]       nmos_mode,
  output wire logic [W-1:0]       pin_out,
  output wire logic [W-1:0]       pin_oe,
  output wire logic [W-1:0]       pull_en,
  // State seen by the parent.
  output wire logic [W-1:0]       latch,
  output wire logic [W-1:0]       dir
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [W-1:0] data_q;
  logic [W-1:0] dir_q;
  logic [W-1:0] pu_q;
  logic [W-1:0] pin_rd;

  wire logic hit_data = tpg_pkg::tpg_hit(core_req.addr, A_DATA);
  wire logic hit_dir  = tpg_pkg::tpg_hit(core_req.addr, A_DIR);
  wire logic hit_pu   = tpg_pkg::tpg_hit(core_req.addr, A_PU);

  // Whole-byte writes in one cycle; bits above W are dropped. [R16] [R2]
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      data_q <= tpg_pkg::RST_DATA[W-1:0]; // [R14]
      dir_q  <= tpg_pkg::RST_DIR[W-1:0];  // [R14]
      pu_q   <= tpg_pkg::RST_PU[W-1:0];   // [R5]
    end else begin
      if (core_req.wr && hit_data) begin
        data_q <= core_req.wdata[W-1:0];  // [R4]
      end
      if (core_req.wr && hit_dir) begin
        dir_q <= core_req.wdata[W-1:0];
      end
      if (core_req.wr && hit_pu) begin
        pu_q <= core_req.wdata[W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-pin drive, pull and readback.
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      wire logic is_in = (dir_q[i] == tpg_pkg::DIR_INPUT);
      // An NMOS output only sinks; it releases the pin for a one. [R11]
      assign pin_oe[i]  = !is_in && !(nmos_mode[i] && data_q[i]);
      assign pin_out[i] = data_q[i];
      // The pull may never fight a pin actively driven high. [R6] [R5]
      assign pull_en[i] = pu_q[i] && (is_in || nmos_mode[i]);
      // Inputs read the live pin, outputs read the latch. [R3] [R12]
      assign pin_rd[i]  = is_in ? pin_in[i] : data_q[i];
    end
  endgenerate

  wire logic [7:0] val_data = 8'({pin_rd});
  wire logic [7:0] val_dir  = 8'({dir_q});
  wire logic [7:0] val_pu   = 8'({pu_q});

  // Unimplemented upper bits read as zero by zero extension. [R2]
  assign rd_hit = hit_data || hit_dir || hit_pu;
  assign rd_val = hit_data ? val_data : (hit_dir ? val_dir : (hit_pu ? val_pu : 8'h00));
  assign latch  = data_q;
  assign dir    = dir_q;

  ////////////////////////////////////////////////////////////////////////////////
  a_pull_gated: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pull_en & ~dir_q & ~nmos_mode) == '0) // [R6]
    else $error("pull-high enabled on a CMOS output pin");

  a_latch_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(core_req.wr && hit_data) |=> (data_q == $past(data_q))) // [R4]
    else $error("output latch changed without a data write");

endmodule

// ==== testbench/tpg_switches.sv ====
`timescale 1ns/10ps
module tpg_switches #(
  parameter int unsigned W = 8
) (
  // Clock.
  input  wire logic         clk_sys,
  // Device side.
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] pull_en,
  // Switch settings.
  input  wire logic [W-1:0] sw_en,
  input  wire logic [W-1:0] sw_val,
  // Resolved pin level.
  output logic [W-1:0]      pin
);
  // A floating pin flips every cycle so a stale level never passes as valid.
  logic [W-1:0] float_pat = {W{1'h0}};
  always @(posedge clk_sys) float_pat <= ~float_pat;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i]) pin[i] = out[i];
      else if (sw_en[i]) pin[i] = sw_val[i];
      else if (pull_en[i]) pin[i] = 1'h1;
      else pin[i] = float_pat[i];
    end
  end
endmodule

// ==== testbench/test_two_port_gpio_with_wakeup.sv ====
`timescale 1ns/10ps
module test_two_port_gpio_with_wakeup;
  logic              clk_sys;
  logic              sys_rst;
  logic              halt_exec;
  logic              core_rvalid;
  logic              power_down;
  logic              wake_req;
  tpg_pkg::tpg_bus_s core_req;
  logic [7:0]        core_rdata;
  logic [7:0]        pa_in, pa_nmos_mode, pa_gpio_sel, pa_out, pa_oe, pa_pull_en;
  logic [7:0]        pa_sw_en, pa_sw_val, w, s;
  logic [5:0]        pb_in, pb_nmos_mode, pb_out, pb_oe, pb_pull_en, pb_sw_en, pb_sw_val;
  logic [7:0]        mreg [7];
  logic              ex;
  int                n_errors, n_compared, k;

  tpg_gpio u_tpg_gpio (.clk_sys(clk_sys), .sys_rst(sys_rst), .core_req(core_req),
    .core_rdata(core_rdata), .core_rvalid(core_rvalid), .pa_in(pa_in),
    .pa_nmos_mode(pa_nmos_mode), .pa_gpio_sel(pa_gpio_sel), .pa_out(pa_out), .pa_oe(pa_oe),
    .pa_pull_en(pa_pull_en), .pb_in(pb_in), .pb_nmos_mode(pb_nmos_mode), .pb_out(pb_out),
    .pb_oe(pb_oe), .pb_pull_en(pb_pull_en), .halt_exec(halt_exec),
    .power_down(power_down), .wake_req(wake_req));
  tpg_switches #(.W(8)) u_sw_a (.clk_sys(clk_sys), .out(pa_out), .oe(pa_oe),
    .pull_en(pa_pull_en), .sw_en(pa_sw_en), .sw_val(pa_sw_val), .pin(pa_in));
  tpg_switches #(.W(6)) u_sw_b (.clk_sys(clk_sys), .out(pb_out), .oe(pb_oe),
    .pull_en(pb_pull_en), .sw_en(pb_sw_en), .sw_val(pb_sw_val), .pin(pb_in));

  always #2.5 clk_sys = ~clk_sys;

  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Held until the next call, so back-to-back accesses need no idle cycle.
  task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
    core_req = '{addr: a, wr: wr, rd: ~wr, wdata: d};
    @(negedge clk_sys);
  endtask

  task automatic wr_reg(input int i, input logic [7:0] d);
    bus(tpg_pkg::ADDR_PA_DATA + 8'(i), 1'h1, d);
    mreg[i] = (i >= 4) ? d & 8'h3f : d;
  endtask

  function automatic logic [7:0] exp_rd(input int i);
    logic [7:0] pin;
    pin = (i == 0) ? (pa_sw_en & pa_sw_val) | ~pa_sw_en
                   : {2'h0, (pb_sw_en & pb_sw_val) | ~pb_sw_en};
    if (i == 0 || i == 4) return (mreg[i+1] & pin) | (~mreg[i+1] & mreg[i]);
    return mreg[i];
  endfunction

  task automatic read_all;
    for (int i = 0; i < 8; i++) begin
      bus((i == 7) ? 8'h20 : tpg_pkg::ADDR_PA_DATA + 8'(i), 1'h0, 8'h00);
      check(8'(core_rvalid), 8'h01);
      check(core_rdata, (i == 7) ? 8'h00 : exp_rd(i));
    end
  endtask

  task automatic pins_chk;
    check(pa_out, mreg[0]);
    check(pa_oe, ~mreg[1] & ~(pa_nmos_mode & mreg[0]));
    check(pa_pull_en, mreg[2] & (mreg[1] | pa_nmos_mode));
    check({2'h0, pb_out}, mreg[4]);
    check({2'h0, pb_oe}, ~mreg[5] & ~({2'h0, pb_nmos_mode} & mreg[4]) & 8'h3f);
    check({2'h0, pb_pull_en}, mreg[6] & (mreg[5] | {2'h0, pb_nmos_mode}));
  endtask

  ////////////////////////////////////////
  initial begin
    #200000;
    n_errors++;
    close_out();
  end

  initial begin
    clk_sys = 1'h0;
    sys_rst = 1'h1;
    core_req = '0;
    halt_exec = 1'h0;
    pa_nmos_mode = 8'h00;
    pb_nmos_mode = 6'h00;
    pa_gpio_sel = 8'hff;
    pa_sw_en = 8'hff;
    pa_sw_val = 8'hff;
    pb_sw_en = 6'h3f;
    pb_sw_val = 6'h3f;
    n_errors = 0;
    n_compared = 0;
    void'($urandom(32'h4eb4));
    mreg = '{tpg_pkg::RST_DATA, tpg_pkg::RST_DIR, tpg_pkg::RST_PU, tpg_pkg::RST_WAKE,
             tpg_pkg::RST_DATA & 8'h3f, tpg_pkg::RST_DIR & 8'h3f, tpg_pkg::RST_PU};
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'h0;
    pins_chk();
    read_all();
    // Wake: bit 7 is always armed, so each round ends awake.
    for (int r = 0; r < 4; r++) begin
      w = 8'($urandom) | 8'h80;
      s = 8'($urandom) | 8'h80;
      wr_reg(3, w);
      core_req = '0;
      pa_gpio_sel = s;
      pa_sw_val = 8'h7f;
      #1 check(8'(wake_req), 8'h00);
      @(negedge clk_sys);
      pa_sw_val = 8'hff;
      halt_exec = 1'h1;
      @(negedge clk_sys);
      halt_exec = 1'h0;
      check(8'(power_down), 8'h01);
      for (int n = 0; n < 8; n++) begin
        pa_sw_val = ~(8'h01 << n);
        ex = w[n] & s[n];
        #1 check(8'(wake_req), 8'(ex));
        @(negedge clk_sys);
        pa_sw_val = 8'hff;
        if (ex) begin
          check(8'(power_down), 8'h00);
          check(8'(wake_req), 8'h01);
          @(negedge clk_sys);
          check(8'(wake_req), 8'h00);
          break;
        end
        @(negedge clk_sys);
      end
    end
    // Random writes, unmapped address included, then a full read-back.
    for (int it = 0; it < 30; it++) begin
      k = $urandom % 8;
      if (k == 7) bus(8'h20, 1'h1, 8'($urandom));
      else wr_reg(k, 8'($urandom));
      pa_nmos_mode = 8'($urandom);
      pb_nmos_mode = 6'($urandom);
      pa_sw_en = 8'($urandom) | ~mreg[2];
      pb_sw_en = 6'($urandom) | ~mreg[6][5:0];
      pa_sw_val = 8'($urandom);
      pb_sw_val = 6'($urandom);
      core_req = '0;
      @(negedge clk_sys);
      pins_chk();
      read_all();
      core_req = '0;
      @(negedge clk_sys);
    end
    close_out();
  end
endmodule
